// ### rtl/btdu_comparator.sv
// one 16-bit address comparator with direction qualification
`timescale 1ns/1ps
`default_nettype none
module btdu_comparator (
   input wire logic [15:0] value,
   input wire btdu_pkg::btdu_bus_s bus,
   input wire logic dirCheck,
   input wire logic dirRead,
   output logic hit,
   output logic equal
);
   always_comb begin
      equal = bus.valid && (bus.addr == value);
      hit = equal && (!dirCheck || (bus.read == dirRead));
   end
endmodule
`default_nettype wire

// ### rtl/btdu_pkg.sv
// shared constants and types for the bus trace debug unit
package btdu_pkg;
   localparam logic [7:0] BTDU_OFS_CMP_A_HIGH = 8'h00;
   localparam logic [7:0] BTDU_OFS_CMP_A_LOW = 8'h01;
   localparam logic [7:0] BTDU_OFS_CMP_B_HIGH = 8'h02;
   localparam logic [7:0] BTDU_OFS_CMP_B_LOW = 8'h03;
   localparam logic [7:0] BTDU_OFS_TRACE_HIGH = 8'h04;
   localparam logic [7:0] BTDU_OFS_TRACE_LOW = 8'h05;
   localparam logic [7:0] BTDU_OFS_CONTROL = 8'h06;
   localparam logic [7:0] BTDU_OFS_TRIGGER = 8'h07;
   localparam logic [7:0] BTDU_OFS_STATUS = 8'h08;
   localparam logic [7:0] BTDU_OFS_FORCE_RESET = 8'h09;
   localparam int BTDU_BIT_ENABLE = 7;
   localparam int BTDU_BIT_ARM = 6;
   localparam int BTDU_BIT_TAG = 5;
   localparam int BTDU_BIT_BREAK_REQUEST_ENABLE = 4;
   localparam int BTDU_BIT_RWA = 3;
   localparam int BTDU_BIT_DIRECTION_CHECK_FIRST = 2;
   localparam int BTDU_BIT_RWB = 1;
   localparam int BTDU_BIT_DIRECTION_CHECK_SECOND = 0;
   localparam int BTDU_BIT_FORCE_RESET = 0;
   localparam int BTDU_BIT_TRG_SEL = 7;
   localparam int BTDU_BIT_BEGIN = 6;
   localparam logic [7:0] BTDU_RST_BYTE = 8'h00;
   localparam logic [15:0] BTDU_RST_WORD = 16'h0000;
   localparam int BTDU_DEPTH = 8;
   localparam logic [3:0] BTDU_MODE_A_ONLY = 4'h0;
   localparam logic [3:0] BTDU_MODE_A_OR_B = 4'h1;
   localparam logic [3:0] BTDU_MODE_EVENT_B = 4'h3;
   localparam logic [3:0] BTDU_MODE_A_THEN_EV = 4'h4;
   localparam logic [3:0] BTDU_MODE_A_AND_B = 4'h5;
   localparam logic [3:0] BTDU_MODE_A_NOT_B = 4'h6;
   localparam logic [3:0] BTDU_MODE_INSIDE = 4'h7;
   localparam logic [3:0] BTDU_MODE_OUTSIDE = 4'h8;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
      logic read;
      logic valid;
      logic opcodeFetch;
   } btdu_bus_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic write;
      logic read;
      logic serial;
   } btdu_reg_s;

   typedef enum logic [2:0] {
      BTDU_IDLE = 3'b001,
      BTDU_WAIT = 3'b010,
      BTDU_STORE = 3'b100
   } btdu_run_e;
endpackage

// ### rtl/btdu_top.sv
// bus trace debug unit: comparators, trace buffer, breakpoint, forced reset
// How it works
// - breakpoint address written only through the bkptWrite port
// - forced reset: serial writes only, reads zero
// - serial write of bit0 resets the chip
// - comparator bytes reset zero, writable unarmed
// - high byte upper, low byte lower bits
// - trace high port read-only, zero in event modes
// - low read advances, high read does not
// - event modes store data byte only
// - no advance on low reads while armed
// - unarmed low read stores last opcode address
// - profiling acts as eight-deep delay
// - control register always readable and writable
// - enable refused while secured
// - arm set by write, cleared by completion
// - bit5 selects tag or force break
// - break on trigger or buffer full
// - comparator A direction qualification
// - comparator B direction qualification
// - breakpoint disabled ignores address and select
// - force breaks at boundary, else tags opcode
// - run ends on full or trigger
`timescale 1ns/1ps
`default_nettype none
module btdu_top (
   input wire logic mclk,
   input wire logic reset_n,
   input wire btdu_pkg::btdu_bus_s bus,
   input wire btdu_pkg::btdu_reg_s regReq,
   input wire logic secured,
   input wire logic breakpointEnable,
   input wire logic forceOrTagSelect,
   input wire logic bkptWrite,
   input wire logic [15:0] bkptWdata,
   output logic [15:0] bkptRdata,
   output logic [7:0] rdata,
   output logic forceSystemReset,
   output logic breakForce,
   output logic breakTag,
   output logic bkptForce,
   output logic bkptTag
);
   logic [15:0] bkptAddr, next_bkptAddr;
   logic [7:0] cmpAH, cmpAL, cmpBH, cmpBL, control, trigger;
   logic [7:0] next_cmpAH, next_cmpAL, next_cmpBH, next_cmpBL, next_control, next_trigger;
   logic [15:0] fifo [0:7];
   logic [15:0] next_fifo [0:7];
   logic [3:0] count, next_count;
   logic flagA, flagB, next_flagA, next_flagB;
   logic resetPulse, next_resetPulse;
   logic breakPulse, next_breakPulse;
   logic [15:0] lastOpcode, next_lastOpcode;
   btdu_pkg::btdu_run_e runState, next_runState;
   logic hitA, hitB, eqA, eqB, armed, enabled, eventMode, beginTrace, trig, store;
   logic wrUser, rdLow, full;
   logic [15:0] valA, valB;

   assign valA = {cmpAH, cmpAL};
   assign valB = {cmpBH, cmpBL};
   assign armed = control[btdu_pkg::BTDU_BIT_ARM];
   assign enabled = control[btdu_pkg::BTDU_BIT_ENABLE];
   assign eventMode = (trigger[3:0] == btdu_pkg::BTDU_MODE_EVENT_B) ||
                      (trigger[3:0] == btdu_pkg::BTDU_MODE_A_THEN_EV);
   assign beginTrace = trigger[btdu_pkg::BTDU_BIT_BEGIN] || eventMode;
   assign wrUser = regReq.write;
   assign rdLow = regReq.read && (regReq.addr == btdu_pkg::BTDU_OFS_TRACE_LOW);
   assign full = (count == 4'(btdu_pkg::BTDU_DEPTH));

   btdu_comparator cmpA (
      .value(valA),
      .bus(bus),
      .dirCheck(control[btdu_pkg::BTDU_BIT_DIRECTION_CHECK_FIRST]),
      .dirRead(control[btdu_pkg::BTDU_BIT_RWA]),
      .hit(hitA),
      .equal(eqA)
   );
   btdu_comparator cmpB (
      .value(valB),
      .bus(bus),
      .dirCheck(control[btdu_pkg::BTDU_BIT_DIRECTION_CHECK_SECOND]),
      .dirRead(control[btdu_pkg::BTDU_BIT_RWB]),
      .hit(hitB),
      .equal(eqB)
   );

   // trigger condition per mode; inside/outside use raw address order
   always_comb begin
      unique case (trigger[3:0])
         btdu_pkg::BTDU_MODE_A_ONLY: trig = hitA;
         btdu_pkg::BTDU_MODE_A_OR_B: trig = hitA || hitB;
         btdu_pkg::BTDU_MODE_EVENT_B: trig = hitB;
         btdu_pkg::BTDU_MODE_A_THEN_EV: trig = flagA && hitB;
         btdu_pkg::BTDU_MODE_A_AND_B: trig = hitA && (bus.data == cmpBL);
         btdu_pkg::BTDU_MODE_A_NOT_B: trig = hitA && (bus.data != cmpBL);
         btdu_pkg::BTDU_MODE_INSIDE: trig = bus.valid && bus.addr >= valA && bus.addr <= valB;
         btdu_pkg::BTDU_MODE_OUTSIDE: trig = bus.valid && (bus.addr < valA || bus.addr > valB);
         4'h2: trig = flagA && hitB;
         default: trig = 1'b0;
      endcase
   end

   always_comb begin
      next_bkptAddr = bkptAddr;
      next_cmpAH = cmpAH;
      next_cmpAL = cmpAL;
      next_cmpBH = cmpBH;
      next_cmpBL = cmpBL;
      next_control = control;
      next_trigger = trigger;
      next_count = count;
      next_flagA = flagA;
      next_flagB = flagB;
      next_runState = runState;
      next_resetPulse = 1'b0;
      next_breakPulse = 1'b0;
      next_lastOpcode = bus.valid && bus.opcodeFetch ? bus.addr : lastOpcode;
      store = 1'b0;
      for (int i = 0; i < btdu_pkg::BTDU_DEPTH; i++) next_fifo[i] = fifo[i];
      if (bkptWrite) next_bkptAddr = bkptWdata;
      if (wrUser && !armed) begin
         unique case (regReq.addr)
            btdu_pkg::BTDU_OFS_CMP_A_HIGH: next_cmpAH = regReq.wdata;
            btdu_pkg::BTDU_OFS_CMP_A_LOW: next_cmpAL = regReq.wdata;
            btdu_pkg::BTDU_OFS_CMP_B_HIGH: next_cmpBH = regReq.wdata;
            btdu_pkg::BTDU_OFS_CMP_B_LOW: next_cmpBL = regReq.wdata;
            btdu_pkg::BTDU_OFS_TRIGGER: next_trigger = regReq.wdata & 8'hcf;
            default: ;
         endcase
      end
      if (wrUser && regReq.serial && regReq.addr == btdu_pkg::BTDU_OFS_FORCE_RESET)
         next_resetPulse = regReq.wdata[btdu_pkg::BTDU_BIT_FORCE_RESET];
      if (wrUser && regReq.addr == btdu_pkg::BTDU_OFS_CONTROL) begin
         next_control = regReq.wdata;
         next_control[btdu_pkg::BTDU_BIT_ENABLE] = regReq.wdata[btdu_pkg::BTDU_BIT_ENABLE] && !secured;
         next_control[btdu_pkg::BTDU_BIT_ARM] = regReq.wdata[btdu_pkg::BTDU_BIT_ARM] &&
                                               next_control[btdu_pkg::BTDU_BIT_ENABLE];
         if (next_control[btdu_pkg::BTDU_BIT_ARM] && !armed) begin
            next_count = 4'h0;
            next_flagA = 1'b0;
            next_flagB = 1'b0;
            next_runState = beginTrace ? btdu_pkg::BTDU_WAIT : btdu_pkg::BTDU_STORE;
         end
         if (!next_control[btdu_pkg::BTDU_BIT_ARM]) next_runState = btdu_pkg::BTDU_IDLE;
      end else if (armed && enabled) begin
         if (hitA) next_flagA = 1'b1;
         if (hitB) next_flagB = 1'b1;
         unique case (runState)
            btdu_pkg::BTDU_IDLE: ;
            btdu_pkg::BTDU_WAIT: if (trig) begin
               next_runState = btdu_pkg::BTDU_STORE;
               store = 1'b1;
            end
            btdu_pkg::BTDU_STORE: begin
               if (beginTrace) store = bus.valid && (eventMode ? hitB : bus.opcodeFetch);
               else if (trig) begin
                  next_control[btdu_pkg::BTDU_BIT_ARM] = 1'b0;
                  next_runState = btdu_pkg::BTDU_IDLE;
                  next_breakPulse = control[btdu_pkg::BTDU_BIT_BREAK_REQUEST_ENABLE];
               end else store = bus.valid && bus.opcodeFetch;
            end
            default: next_runState = btdu_pkg::BTDU_IDLE;
         endcase
         if (store) begin
            for (int i = 0; i < btdu_pkg::BTDU_DEPTH - 1; i++) next_fifo[i] = fifo[i + 1];
            next_fifo[btdu_pkg::BTDU_DEPTH - 1] = eventMode ? {8'h00, bus.data} : bus.addr;
            if (!full) next_count = count + 4'h1;
            if (beginTrace && count == 4'(btdu_pkg::BTDU_DEPTH - 1)) begin
               next_control[btdu_pkg::BTDU_BIT_ARM] = 1'b0;
               next_runState = btdu_pkg::BTDU_IDLE;
               next_breakPulse = control[btdu_pkg::BTDU_BIT_BREAK_REQUEST_ENABLE];
            end
         end
      end
      // armed reads of the low port leave the buffer still
      if (rdLow && !armed) begin
         for (int i = 0; i < btdu_pkg::BTDU_DEPTH - 1; i++) next_fifo[i] = fifo[i + 1];
         next_fifo[btdu_pkg::BTDU_DEPTH - 1] = lastOpcode;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         bkptAddr <= btdu_pkg::BTDU_RST_WORD;
         cmpAH <= btdu_pkg::BTDU_RST_BYTE;
         cmpAL <= btdu_pkg::BTDU_RST_BYTE;
         cmpBH <= btdu_pkg::BTDU_RST_BYTE;
         cmpBL <= btdu_pkg::BTDU_RST_BYTE;
         control <= btdu_pkg::BTDU_RST_BYTE;
         trigger <= btdu_pkg::BTDU_RST_BYTE;
         count <= 4'h0;
         flagA <= 1'b0;
         flagB <= 1'b0;
         resetPulse <= 1'b0;
         breakPulse <= 1'b0;
         lastOpcode <= btdu_pkg::BTDU_RST_WORD;
         runState <= btdu_pkg::BTDU_IDLE;
         for (int i = 0; i < btdu_pkg::BTDU_DEPTH; i++) fifo[i] <= btdu_pkg::BTDU_RST_WORD;
      end else begin
         bkptAddr <= next_bkptAddr;
         cmpAH <= next_cmpAH;
         cmpAL <= next_cmpAL;
         cmpBH <= next_cmpBH;
         cmpBL <= next_cmpBL;
         control <= next_control;
         trigger <= next_trigger;
         count <= next_count;
         flagA <= next_flagA;
         flagB <= next_flagB;
         resetPulse <= next_resetPulse;
         breakPulse <= next_breakPulse;
         lastOpcode <= next_lastOpcode;
         runState <= next_runState;
         for (int i = 0; i < btdu_pkg::BTDU_DEPTH; i++) fifo[i] <= next_fifo[i];
      end
   end

   always_comb begin
      unique case (regReq.addr)
         btdu_pkg::BTDU_OFS_CMP_A_HIGH: rdata = cmpAH;
         btdu_pkg::BTDU_OFS_CMP_A_LOW: rdata = cmpAL;
         btdu_pkg::BTDU_OFS_CMP_B_HIGH: rdata = cmpBH;
         btdu_pkg::BTDU_OFS_CMP_B_LOW: rdata = cmpBL;
         btdu_pkg::BTDU_OFS_TRACE_HIGH: rdata = eventMode ? 8'h00 : fifo[0][15:8];
         btdu_pkg::BTDU_OFS_TRACE_LOW: rdata = fifo[0][7:0];
         btdu_pkg::BTDU_OFS_CONTROL: rdata = control;
         btdu_pkg::BTDU_OFS_TRIGGER: rdata = trigger;
         btdu_pkg::BTDU_OFS_STATUS: rdata = {flagA, flagB, armed, 1'b0, count};
         default: rdata = 8'h00;
      endcase
   end

   always_comb begin
      bkptRdata = bkptAddr;
      forceSystemReset = resetPulse;
      breakForce = breakPulse && !control[btdu_pkg::BTDU_BIT_TAG];
      breakTag = breakPulse && control[btdu_pkg::BTDU_BIT_TAG];
      bkptForce = breakpointEnable && forceOrTagSelect && bus.valid && bus.addr == bkptAddr;
      bkptTag = breakpointEnable && !forceOrTagSelect && bus.valid && bus.opcodeFetch &&
                bus.addr == bkptAddr;
   end

   property userResetIgnored;
      @(posedge mclk) disable iff (!reset_n)
         (regReq.write && !regReq.serial && regReq.addr == btdu_pkg::BTDU_OFS_FORCE_RESET) |=> !forceSystemReset;
   endproperty
   user_reset_ignored_a: assert property (userResetIgnored) else $error("user write forced reset");
   serial_reset_fires_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (regReq.write && regReq.serial && regReq.addr == btdu_pkg::BTDU_OFS_FORCE_RESET && regReq.wdata[0])
      |=> forceSystemReset) else $error("serial reset missing");
   cmp_locked_armed_a: assert property (@(posedge mclk) disable iff (!reset_n)
      armed |=> (cmpAH == $past(cmpAH))) else $error("comparator changed while armed");
   secure_no_enable_a: assert property (@(posedge mclk) disable iff (!reset_n)
      secured && !enabled |=> !enabled) else $error("enable set while secured");
   armed_fifo_still_a: assert property (@(posedge mclk) disable iff (!reset_n)
      armed && rdLow && !store |=> fifo[0] == $past(fifo[0])) else $error("fifo moved on armed read");
   sequence unarmedLowRead;
      !armed && rdLow;
   endsequence
   profile_store_a: assert property (@(posedge mclk) disable iff (!reset_n)
      unarmedLowRead |=> fifo[7] == $past(lastOpcode)) else $error("opcode address not stored");
   high_zero_event_a: assert property (@(posedge mclk) disable iff (!reset_n)
      eventMode && regReq.addr == btdu_pkg::BTDU_OFS_TRACE_HIGH |-> rdata == 8'h00)
      else $error("high port nonzero");
   break_type_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !(breakForce && breakTag)) else $error("both break types");
   bkpt_disabled_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !breakpointEnable |-> !bkptForce && !bkptTag) else $error("breakpoint while disabled");
endmodule
`default_nettype wire

// ### tb/btdu_cpu_model.sv
// cpu bus model: drives one bus cycle on request, scrambled lines while idle
`timescale 1ns/1ps
`default_nettype none
module btdu_cpu_model (
   input wire logic mclk,
   output var btdu_pkg::btdu_bus_s bus
);
   initial begin
      bus = '0;
      bus.addr = 16'hffff;
   end

   // idle cycles show inverted lines so a stale address never matches by accident
   task automatic cycle(input logic [15:0] addr, input logic rd, input logic fetch, input logic [7:0] data);
      @(negedge mclk);
      bus.addr = addr;
      bus.data = data;
      bus.read = rd;
      bus.valid = 1'b1;
      bus.opcodeFetch = fetch;
      @(negedge mclk);
      bus.addr = ~addr;
      bus.data = ~data;
      bus.read = ~rd;
      bus.valid = 1'b0;
      bus.opcodeFetch = 1'b0;
   endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking testbench for the bus trace debug unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   btdu_pkg::btdu_bus_s bus;
   btdu_pkg::btdu_reg_s regReq = '0;
   logic secured = 1'b0;
   logic breakpointEnable = 1'b0;
   logic forceOrTagSelect = 1'b0;
   logic bkptWrite = 1'b0;
   logic [15:0] bkptWdata = 16'h0000;
   logic [15:0] bkptRdata;
   logic [7:0] rdata;
   logic forceSystemReset, breakForce, breakTag, bkptForce, bkptTag;
   int num_errors = 0;
   int checked = 0;

   always #5 mclk = ~mclk;

   btdu_cpu_model cpu (.mclk(mclk), .bus(bus));
   btdu_top uut (.mclk(mclk), .reset_n(reset_n), .bus(bus), .regReq(regReq), .secured(secured),
      .breakpointEnable(breakpointEnable), .forceOrTagSelect(forceOrTagSelect), .bkptWrite(bkptWrite),
      .bkptWdata(bkptWdata), .bkptRdata(bkptRdata), .rdata(rdata), .forceSystemReset(forceSystemReset),
      .breakForce(breakForce), .breakTag(breakTag), .bkptForce(bkptForce), .bkptTag(bkptTag));

   task automatic results();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, seen);
         num_errors++;
      end
   endtask

   task automatic acc(input logic [7:0] a, input logic [7:0] wd, input logic wr, input logic ser,
      output logic [7:0] rd);
      @(negedge mclk);
      regReq.addr = a;
      regReq.wdata = wd;
      regReq.write = wr;
      regReq.read = ~wr;
      regReq.serial = ser;
      #1 rd = rdata;
      @(negedge mclk);
      regReq.write = 1'b0;
      regReq.read = 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ser = 1'b0);
      logic [7:0] dummy;
      acc(a, d, 1'b1, ser, dummy);
   endtask

   task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      acc(a, 8'h00, 1'b0, 1'b0, v);
      check(n, {8'h00, v}, {8'h00, exp});
   endtask

   // pulses may already stand when called, so sample before each wait
   task automatic watch(output int f, output int t, output int r);
      f = 0;
      t = 0;
      r = 0;
      repeat (6) begin
         if (breakForce === 1'b1) f++;
         if (breakTag === 1'b1) t++;
         if (forceSystemReset === 1'b1) r++;
         @(negedge mclk);
      end
   endtask

   task automatic test_reset_values();
      for (int i = 0; i < 4; i++) rchk("comparator reset", 8'(i), 8'h00);
      rchk("force reset read", btdu_pkg::BTDU_OFS_FORCE_RESET, 8'h00);
      rchk("control reset", btdu_pkg::BTDU_OFS_CONTROL, 8'h00);
      rchk("unmapped read", 8'h0a, 8'h00);
      $display("test reset_values done");
   endtask

   task automatic test_comparators();
      wr(btdu_pkg::BTDU_OFS_CMP_A_HIGH, 8'h30);
      wr(btdu_pkg::BTDU_OFS_CMP_A_LOW, 8'h00);
      wr(btdu_pkg::BTDU_OFS_CMP_B_HIGH, 8'h40);
      wr(btdu_pkg::BTDU_OFS_CMP_B_LOW, 8'h00);
      rchk("cmp a high", btdu_pkg::BTDU_OFS_CMP_A_HIGH, 8'h30);
      rchk("cmp b high", btdu_pkg::BTDU_OFS_CMP_B_HIGH, 8'h40);
      wr(btdu_pkg::BTDU_OFS_TRIGGER, 8'h00);
      wr(btdu_pkg::BTDU_OFS_CONTROL, 8'hc0);
      wr(btdu_pkg::BTDU_OFS_CMP_A_HIGH, 8'h77);
      rchk("cmp a armed", btdu_pkg::BTDU_OFS_CMP_A_HIGH, 8'h30);
      rchk("control armed", btdu_pkg::BTDU_OFS_CONTROL, 8'hc0);
      wr(btdu_pkg::BTDU_OFS_CONTROL, 8'h80);
      rchk("control disarmed", btdu_pkg::BTDU_OFS_CONTROL, 8'h80);
      secured = 1'b1;
      wr(btdu_pkg::BTDU_OFS_CONTROL, 8'h00);
      wr(btdu_pkg::BTDU_OFS_CONTROL, 8'h80);
      rchk("enable secured", btdu_pkg::BTDU_OFS_CONTROL, 8'h00);
      secured = 1'b0;
      $display("test comparators done");
   endtask

   task automatic brk(input logic [7:0] ctrl, input logic [7:0] trig, input logic [15:0] a, input logic rd,
      input int expF, input int expT, input logic ends);
      int f, t, r;
      wr(btdu_pkg::BTDU_OFS_CONTROL, 8'h80);
      wr(btdu_pkg::BTDU_OFS_TRIGGER, trig);
      wr(btdu_pkg::BTDU_OFS_CONTROL, ctrl);
      cpu.cycle(a, rd, 1'b0, a[7:0]);
      watch(f, t, r);
      check("force break", 16'(f), 16'(expF));
      check("tag break", 16'(t), 16'(expT));
      // a cycle that misses leaves the run armed
      rchk("arm after run", btdu_pkg::BTDU_OFS_CONTROL, ends ? ctrl & 8'hbf : ctrl);
   endtask

   task automatic test_breaks();
      brk(8'hdc, 8'h00, 16'h3000, 1'b0, 0, 0, 1'b0);
      wr(btdu_pkg::BTDU_OFS_CONTROL, 8'h80);
      brk(8'hdc, 8'h00, 16'h3000, 1'b1, 1, 0, 1'b1);
      brk(8'hd4, 8'h00, 16'h3000, 1'b0, 1, 0, 1'b1);
      brk(8'hf0, 8'h00, 16'h3000, 1'b1, 0, 1, 1'b1);
      brk(8'hd3, 8'h01, 16'h4000, 1'b1, 1, 0, 1'b1);
      brk(8'hd1, 8'h01, 16'h4000, 1'b0, 1, 0, 1'b1);
      brk(8'hc0, 8'h00, 16'h3000, 1'b1, 0, 0, 1'b1);
      rchk("run ended no break", btdu_pkg::BTDU_OFS_CONTROL, 8'h80);
      $display("test breaks done");
   endtask

   task automatic test_profile();
      logic [7:0] h, h2, l;
      wr(btdu_pkg::BTDU_OFS_CONTROL, 8'h80);
      wr(btdu_pkg::BTDU_OFS_TRIGGER, 8'h00);
      // the first eight reads only prime the delay line
      for (int i = 0; i < 16; i++) begin
         cpu.cycle(16'h2000 + 16'(i), 1'b1, 1'b1, 8'h00);
         acc(btdu_pkg::BTDU_OFS_TRACE_HIGH, 8'h00, 1'b0, 1'b0, h);
         acc(btdu_pkg::BTDU_OFS_TRACE_HIGH, 8'h00, 1'b0, 1'b0, h2);
         acc(btdu_pkg::BTDU_OFS_TRACE_LOW, 8'h00, 1'b0, 1'b0, l);
         check("high read stable", {8'h00, h2}, {8'h00, h});
         if (i >= 8) check("profile word", {h, l}, 16'h2000 + 16'(i - 8));
      end
      wr(btdu_pkg::BTDU_OFS_TRIGGER, 8'h03);
      cpu.cycle(16'habcd, 1'b1, 1'b1, 8'hcd);
      acc(btdu_pkg::BTDU_OFS_TRACE_LOW, 8'h00, 1'b0, 1'b0, l);
      wr(btdu_pkg::BTDU_OFS_TRACE_HIGH, 8'h55);
      rchk("event high zero", btdu_pkg::BTDU_OFS_TRACE_HIGH, 8'h00);
      $display("test profile done");
   endtask

   task automatic test_event();
      int f, t, r;
      logic [7:0] h, l;
      wr(btdu_pkg::BTDU_OFS_CONTROL, 8'h80);
      wr(btdu_pkg::BTDU_OFS_TRIGGER, 8'hf3);
      // bits 5:4 of the trigger byte are hard-wired zero
      rchk("trigger bits", btdu_pkg::BTDU_OFS_TRIGGER, 8'hc3);
      wr(btdu_pkg::BTDU_OFS_CONTROL, 8'hd0);
      for (int i = 0; i < 8; i++) begin
         cpu.cycle(16'h4000, 1'b0, 1'b0, 8'h10 + 8'(i));
         // a shift here would push a stray word into the capture
         if (i == 3) acc(btdu_pkg::BTDU_OFS_TRACE_LOW, 8'h00, 1'b0, 1'b0, l);
      end
      watch(f, t, r);
      check("full break", 16'(f), 16'h0001);
      rchk("full status", btdu_pkg::BTDU_OFS_STATUS, 8'h48);
      rchk("full disarmed", btdu_pkg::BTDU_OFS_CONTROL, 8'h90);
      wr(btdu_pkg::BTDU_OFS_TRIGGER, 8'h00);
      for (int i = 0; i < 8; i++) begin
         acc(btdu_pkg::BTDU_OFS_TRACE_HIGH, 8'h00, 1'b0, 1'b0, h);
         acc(btdu_pkg::BTDU_OFS_TRACE_LOW, 8'h00, 1'b0, 1'b0, l);
         check("event word", {h, l}, {8'h00, 8'h10 + 8'(i)});
      end
      $display("test event done");
   endtask

   task automatic bkc(input logic en, input logic sel, input logic expF, input logic expT);
      breakpointEnable = en;
      forceOrTagSelect = sel;
      fork
         cpu.cycle(16'h1234, 1'b1, 1'b1, 8'h34);
         begin
            @(negedge mclk);
            #2 check("bkpt force", {15'h0, bkptForce}, {15'h0, expF});
            check("bkpt tag", {15'h0, bkptTag}, {15'h0, expT});
         end
      join
   endtask

   task automatic test_breakpoint();
      @(negedge mclk);
      bkptWrite = 1'b1;
      bkptWdata = 16'h1234;
      @(negedge mclk);
      bkptWrite = 1'b0;
      wr(8'h0a, 8'h99);
      check("bkpt register", bkptRdata, 16'h1234);
      bkc(1'b1, 1'b1, 1'b1, 1'b0);
      bkc(1'b1, 1'b0, 1'b0, 1'b1);
      bkc(1'b0, 1'b1, 1'b0, 1'b0);
      $display("test breakpoint done");
   endtask

   task automatic test_force_reset();
      int f, t, r;
      wr(btdu_pkg::BTDU_OFS_FORCE_RESET, 8'h01, 1'b0);
      watch(f, t, r);
      check("user force reset", 16'(r), 16'h0000);
      wr(btdu_pkg::BTDU_OFS_FORCE_RESET, 8'h01, 1'b1);
      watch(f, t, r);
      check("serial force reset", 16'(r), 16'h0001);
      reset_n = 1'b0;
      repeat (3) @(negedge mclk);
      reset_n = 1'b1;
      rchk("control after reset", btdu_pkg::BTDU_OFS_CONTROL, 8'h00);
      $display("test force_reset done");
   endtask

   initial begin
      #100000;
      num_errors++;
      results();
   end

   initial begin
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      reset_n = 1'b1;
      test_reset_values();
      test_comparators();
      test_breaks();
      test_profile();
      test_event();
      test_breakpoint();
      test_force_reset();
      results();
   end
endmodule
`default_nettype wire
